// [inc/adc_conv_regs.svh]
`ifndef ADC_CONV_REGS_SVH
`define ADC_CONV_REGS_SVH
// Result width and saturation codes
`define RESULT_WIDTH 10
`define RESULT_ALL_ONES 10'h3ff
`define RESULT_ALL_ZEROS 10'h000
// Conversion time budget, in nanoseconds, and the core clock period
`define CONV_TIME_NS 6000
`define CORE_CLK_PERIOD_NS 20
// Longest conversion in core cycles, rounded down
`define CONV_MAX_CYCLES (`CONV_TIME_NS / `CORE_CLK_PERIOD_NS)
// Internal oscillator: core cycles per successive-approximation step
`define INT_STEP_DIV 8'h0a
`endif

// [inc/adc_conv_pkg.sv]
`default_nettype none
package adc_conv_pkg;
  // Converter sequencing states
  typedef enum logic [2:0] {
    ST_TRACK = 3'b001,
    ST_CONVERT = 3'b010,
    ST_DONE = 3'b100
  } conv_state_t;
endpackage
`default_nettype wire

// [hw/sar_step_unit.sv]
`default_nettype none
`include "adc_conv_regs.svh"
// Successive-approximation register: one bit decided per step pulse.
module sar_step_unit
  import adc_conv_pkg::*;
#(
  parameter int WIDTH = `RESULT_WIDTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Control
  input wire logic start,
  input wire logic step,
  input wire logic compare_high,
  // Result
  output logic [WIDTH-1:0] trial,
  output logic finished
);
  logic [WIDTH-1:0] trial_reg;
  logic [WIDTH-1:0] mask_reg;

  // Trial bit kept when the sampled input is at or above it
  always_ff @(posedge core_clk) begin
    if (srst || start) begin
      trial_reg <= {1'b1, {(WIDTH-1){1'b0}}};
      mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (step && (mask_reg != '0)) begin
      trial_reg <= (compare_high ? trial_reg : (trial_reg & ~mask_reg)) | (mask_reg >> 1);
      mask_reg <= mask_reg >> 1;
    end
  end

  assign trial = trial_reg;
  assign finished = (mask_reg == '0);
endmodule
`default_nettype wire

// [hw/adc_conversion_host_port.sv]
// Function
// R1 - Strobes count only while unit selected
// R2 - Track from done rising until start
// R3 - Write rising edge starts hold, conversion
// R4 - Clocked conversion finishes within six microseconds
// R5 - Latch result first, then assert done
// R6 - Select plus read: release done, drive data
// R7 - Release bus after read strobe rises
// R8 - Saturate result at both references
// R9 - Host maps unit as memory peripheral
// R10 - Ten-bit parallel result, bit zero LSB
// R11 - External clock times steps when present
`default_nettype none
`include "adc_conv_regs.svh"
module adc_conversion_host_port
  import adc_conv_pkg::*;
#(
  parameter int WIDTH = `RESULT_WIDTH,
  parameter logic [7:0] INT_DIV = `INT_STEP_DIV
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Host strobes, active low, asynchronous pins
  input wire logic unit_select_n,
  input wire logic convert_start_n,
  input wire logic output_enable_n,
  // External step clock and its presence strap
  input wire logic external_clock_input,
  input wire logic external_clock_used,
  // Analog input modelled as a digital level and reference limits
  input wire logic [WIDTH-1:0] analog_input,
  input wire logic above_upper_ref,
  input wire logic below_lower_ref,
  // Host data bus, result word plus one shared output enable
  output logic [WIDTH-1:0] data_out,
  output logic data_oe,
  // Status
  output logic conversion_done_n,
  output logic hold_mode
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [WIDTH-1:0] ain_s1_reg;
  logic [WIDTH-1:0] ain_s2_reg;
  logic [1:0] limit_s1_reg;
  logic [1:0] limit_s2_reg;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic ext_clk_s;
  logic ext_used;
  logic wr_n_d_reg;
  logic ext_clk_d_reg;

  // Two flops per pin; reset parks strobes at their idle high level
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_reg <= 5'h07;
      sync2_reg <= 5'h07;
      ain_s1_reg <= '0;
      ain_s2_reg <= '0;
      limit_s1_reg <= 2'h0;
      limit_s2_reg <= 2'h0;
    end else begin
      sync1_reg <= {external_clock_used, external_clock_input, output_enable_n,
                    convert_start_n, unit_select_n};
      sync2_reg <= sync1_reg;
      ain_s1_reg <= analog_input;
      ain_s2_reg <= ain_s1_reg;
      // Reference limit flags are pins too: bit 1 above, bit 0 below
      limit_s1_reg <= {above_upper_ref, below_lower_ref};
      limit_s2_reg <= limit_s1_reg;
    end
  end
  assign cs_n = sync2_reg[0];
  assign wr_n = sync2_reg[1];
  assign rd_n = sync2_reg[2];
  assign ext_clk_s = sync2_reg[3];
  assign ext_used = sync2_reg[4];

  // Edge history of synchronised signals
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_n_d_reg <= 1'b1;
      ext_clk_d_reg <= 1'b0;
    end else begin
      wr_n_d_reg <= wr_n;
      ext_clk_d_reg <= ext_clk_s;
    end
  end

  // R1 select gating
  logic start_evt;
  logic read_act;
  // R3 write rising edge
  assign start_evt = !cs_n && wr_n && !wr_n_d_reg;
  assign read_act = !cs_n && !rd_n;

  // ----------------------------------------
  // Step timing
  // ----------------------------------------
  logic [7:0] div_reg;
  logic int_tick;
  logic step;
  conv_state_t state_reg;

  // Internal oscillator divider, only runs during conversion
  always_ff @(posedge core_clk) begin
    if (srst || state_reg != ST_CONVERT || div_reg == INT_DIV - 8'h01) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
  assign int_tick = (div_reg == INT_DIV - 8'h01);
  // R11 clock source pick
  assign step = (state_reg == ST_CONVERT) &&
                (ext_used ? (ext_clk_s && !ext_clk_d_reg) : int_tick);

  // ----------------------------------------
  // Conversion sequencing
  // ----------------------------------------
  logic [WIDTH-1:0] sample_reg;
  logic [WIDTH-1:0] trial;
  logic finished;
  logic [WIDTH-1:0] result_reg;
  logic done_n_reg;
  logic rd_seen_reg;

  sar_step_unit #(
    .WIDTH(WIDTH)
  ) u_sar (
    .core_clk(core_clk),
    .srst(srst),
    .start(start_evt && state_reg != ST_CONVERT),
    .step(step),
    .compare_high(sample_reg >= trial),
    .trial(trial),
    .finished(finished)
  );

  // R2 track until start
  // Sample follows the input while tracking, frozen in hold
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sample_reg <= '0;
    end else if (state_reg != ST_CONVERT) begin
      sample_reg <= ain_s2_reg;
    end
  end

  // R4 automatic sequencing
  // A new start while converting is ignored to keep the result coherent
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= ST_TRACK;
    end else begin
      unique case (state_reg)
        ST_TRACK: if (start_evt) state_reg <= ST_CONVERT;
        ST_CONVERT: if (finished) state_reg <= ST_DONE;
        ST_DONE: if (start_evt) state_reg <= ST_CONVERT;
      endcase
    end
  end
  assign hold_mode = (state_reg == ST_CONVERT);

  // R8 saturated result code
  // R5 latch then flag
  always_ff @(posedge core_clk) begin
    if (srst) begin
      result_reg <= `RESULT_ALL_ZEROS;
    end else if (state_reg == ST_CONVERT && finished) begin
      if (limit_s2_reg[1]) begin
        result_reg <= `RESULT_ALL_ONES;
      end else if (limit_s2_reg[0]) begin
        result_reg <= `RESULT_ALL_ZEROS;
      end else begin
        result_reg <= trial;
      end
    end
  end

  // Done flag drops one cycle after the latch; a read clears it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      done_n_reg <= 1'b1;
      rd_seen_reg <= 1'b0;
    end else begin
      // One pulse per finished conversion, so a read cannot re-arm the flag
      rd_seen_reg <= (state_reg == ST_CONVERT) && finished;
      // R6 read releases flag; a fresh result beats a read in the same cycle
      if (rd_seen_reg) begin
        done_n_reg <= 1'b0;
      end else if (read_act) begin
        done_n_reg <= 1'b1;
      end
    end
  end
  assign conversion_done_n = done_n_reg;

  // ----------------------------------------
  // Host data bus
  // ----------------------------------------
  // R10 parallel result word
  // R7 release after read
  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_out <= '0;
      data_oe <= 1'b0;
    end else begin
      data_out <= result_reg;
      data_oe <= read_act;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_gate_select: assert property (@(posedge core_clk) disable iff (srst)
    (cs_n && !hold_mode) |=> !hold_mode) // R1
    else $error("start taken while unselected");
  a_start_hold: assert property (@(posedge core_clk) disable iff (srst)
    (start_evt && !hold_mode) |=> hold_mode) // R3
    else $error("write edge did not enter hold");
  a_track_idle: assert property (@(posedge core_clk) disable iff (srst)
    (!hold_mode && !start_evt) |=> !hold_mode) // R2
    else $error("left track without start");
  a_conv_bound: assert property (@(posedge core_clk) disable iff (srst || ext_used)
    $rose(hold_mode) |-> ##[1:300] !hold_mode) // R4
    else $error("conversion too long");
  a_latch_first: assert property (@(posedge core_clk) disable iff (srst)
    $fell(done_n_reg) |-> $past(state_reg) == ST_DONE) // R5
    else $error("done before latch");
  a_read_clear: assert property (@(posedge core_clk) disable iff (srst)
    read_act |=> (done_n_reg || $past(rd_seen_reg)) && data_oe &&
    data_out == $past(result_reg)) // R6
    else $error("read did not clear flag or drive bus");
  a_bus_release: assert property (@(posedge core_clk) disable iff (srst)
    !read_act |=> !data_oe) // R7
    else $error("bus not released");
  a_saturate: assert property (@(posedge core_clk) disable iff (srst)
    (hold_mode && finished && limit_s2_reg[1]) |=> result_reg == `RESULT_ALL_ONES) // R8
    else $error("no saturation at top");
  a_ext_step: assert property (@(posedge core_clk) disable iff (srst)
    (hold_mode && ext_used && !(ext_clk_s && !ext_clk_d_reg)) |-> !step) // R11
    else $error("step without external edge");
  c_convert: cover property (@(posedge core_clk) $fell(done_n_reg));
  c_read: cover property (@(posedge core_clk) read_act ##1 !read_act);
  c_ext: cover property (@(posedge core_clk) ext_used && step);
endmodule
`default_nettype wire

// [test/host_bus_model.sv]
`default_nettype none
// Processor side: decoder select plus write and read strobes
module host_bus_model (
  // Clock
  input wire logic core_clk,
  // Strobes to the converter
  output logic unit_select_n,
  output logic convert_start_n,
  output logic output_enable_n,
  // Data bus from the converter
  input wire logic [9:0] data_out,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] last_bus;
  logic [9:0] bus;
  // Released bus floats to the inverse of its last value, never a copy
  assign bus = data_oe ? data_out : ~last_bus;
  always @(posedge core_clk) if (data_oe) last_bus <= data_out;
  // Idle strobes high
  initial begin
    unit_select_n = 1'b1;
    convert_start_n = 1'b1;
    output_enable_n = 1'b1;
    last_bus = 10'h000;
  end
  task automatic write_cycle(input logic sel);
    @(posedge core_clk) #2;
    unit_select_n = ~sel;
    convert_start_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #2 convert_start_n = 1'b1;
    @(posedge core_clk) #2 unit_select_n = 1'b1;
  endtask
  // read cycle, strobes held until the bus is driven or a bound runs out
  task automatic read_cycle(input logic sel, output logic got, output logic [9:0] word);
    int n;
    got = 1'b0;
    word = 10'h000;
    @(posedge core_clk) #2;
    unit_select_n = ~sel;
    output_enable_n = 1'b0;
    for (n = 0; n < 8 && !got; n++) begin
      @(posedge core_clk) #1;
      if (data_oe === 1'b1) begin
        got = 1'b1;
        word = bus;
      end
    end
    #1 output_enable_n = 1'b1;
    unit_select_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// [test/adc_conversion_host_port_bench.sv]
`default_nettype none
module adc_conversion_host_port_bench;
  import adc_conv_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic external_clock_input = 1'b0;
  logic external_clock_used = 1'b0;
  logic ext_run = 1'b0;
  logic [9:0] analog_input = 10'h000;
  logic above_upper_ref = 1'b0;
  logic below_lower_ref = 1'b0;
  logic [9:0] data_out;
  logic data_oe, conversion_done_n, hold_mode;
  logic unit_select_n, convert_start_n, output_enable_n;
  int mismatches = 0;
  int cmp_count = 0;
  // ----------------------------------------
  // Clocks and instances
  // ----------------------------------------
  always #10 core_clk = ~core_clk;
  // External step clock near 4.2 MHz, held low while not running
  always begin
    repeat (6) @(posedge core_clk);
    #2 external_clock_input = ext_run ? ~external_clock_input : 1'b0;
  end
  adc_conversion_host_port adc_conversion_host_port_inst (.core_clk(core_clk), .srst(srst),
    .unit_select_n(unit_select_n), .convert_start_n(convert_start_n),
    .output_enable_n(output_enable_n), .external_clock_input(external_clock_input),
    .external_clock_used(external_clock_used), .analog_input(analog_input),
    .above_upper_ref(above_upper_ref), .below_lower_ref(below_lower_ref),
    .data_out(data_out), .data_oe(data_oe), .conversion_done_n(conversion_done_n),
    .hold_mode(hold_mode));
  host_bus_model host_bus_model_inst (.core_clk(core_clk), .unit_select_n(unit_select_n),
    .convert_start_n(convert_start_n), .output_enable_n(output_enable_n),
    .data_out(data_out), .data_oe(data_oe));
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One full write, wait, read sequence against an expected code
  task automatic convert_and_read(input logic [9:0] exp);
    int cyc;
    logic got;
    logic [9:0] word;
    host_bus_model_inst.write_cycle(1'b1);
    repeat (3) @(posedge core_clk);
    #2 check({9'h000, hold_mode}, 10'h001);
    for (cyc = 0; cyc < 400 && conversion_done_n !== 1'b0; cyc++) @(posedge core_clk) #2;
    check({9'h000, cyc < 300}, 10'h001);
    check({9'h000, conversion_done_n}, 10'h000);
    host_bus_model_inst.read_cycle(1'b1, got, word);
    check({9'h000, got}, 10'h001);
    check(word, exp);
    check({9'h000, conversion_done_n}, 10'h001);
    repeat (5) @(posedge core_clk);
    #2 check({9'h000, data_oe}, 10'h000);
    check({9'h000, hold_mode}, 10'h000);
    check({9'h000, conversion_done_n}, 10'h001);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic scen_reset();
    check({7'h00, conversion_done_n, data_oe, hold_mode}, 10'h004);
  endtask
  task automatic scen_internal();
    analog_input = 10'h2a5;
    convert_and_read(10'h2a5);
    analog_input = 10'h001;
    convert_and_read(10'h001);
  endtask
  task automatic scen_unselected();
    logic got;
    logic [9:0] word;
    host_bus_model_inst.write_cycle(1'b0);
    repeat (20) @(posedge core_clk);
    #2 check({9'h000, hold_mode}, 10'h000);
    host_bus_model_inst.read_cycle(1'b0, got, word);
    check({9'h000, got}, 10'h000);
  endtask
  task automatic scen_saturate();
    above_upper_ref = 1'b1;
    convert_and_read(10'h3ff);
    above_upper_ref = 1'b0;
    below_lower_ref = 1'b1;
    convert_and_read(10'h000);
    below_lower_ref = 1'b0;
  endtask
  task automatic scen_external();
    external_clock_used = 1'b1;
    analog_input = 10'h15a;
    // Step clock stalled at first: the conversion must wait for it
    fork
      begin
        repeat (150) @(posedge core_clk);
        #2 check({9'h000, hold_mode}, 10'h001);
        ext_run = 1'b1;
      end
    join_none
    convert_and_read(10'h15a);
    ext_run = 1'b0;
    external_clock_used = 1'b0;
  endtask
  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic summarize();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    #2 srst = 1'b0;
    scen_reset();
    scen_internal();
    scen_unselected();
    scen_saturate();
    scen_external();
    summarize();
  end
  // Watchdog well beyond the fewer than a thousand cycles the scenarios need
  initial begin
    #400000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
